// >>> common/pim_consts.vh
// register offsets, field layouts and reset values of the pin interrupt block
`ifndef PIM_CONSTS_VH
`define PIM_CONSTS_VH

`define PIM_CH_N         8
`define PIM_PINS_N       64
`define PIM_SEL_W        6

`define PIM_OFF_SEL0     8'h00
`define PIM_OFF_SEL1     8'h04
`define PIM_OFF_MODE     8'h08
`define PIM_OFF_ENRISE   8'h0c
`define PIM_OFF_ENFALL   8'h10
`define PIM_OFF_EDGEFLAG 8'h14
`define PIM_OFF_PINSTATE 8'h18
`define PIM_OFF_WAKEEN   8'h1c
`define PIM_OFF_PMSRC    8'h20
`define PIM_OFF_PMCFG    8'h24
`define PIM_OFF_PMCTRL   8'h28
`define PIM_OFF_ISTAT    8'h2c
`define PIM_OFF_IMASK    8'h30

`define PIM_SEL_RST      32'h03020100
`define PIM_SEL1_RST     32'h07060504
`define PIM_PMSRC_RST    32'h76543210
`define PIM_PMCFG_RST    32'h00000000

`define PIM_PMCTRL_EVEN  0
`define PIM_PMCTRL_TERMS 24

`define PIM_COND_HIGH1   3'h0
`define PIM_COND_RISE    3'h1
`define PIM_COND_FALL    3'h2
`define PIM_COND_EITHER  3'h3
`define PIM_COND_LVLHI   3'h4
`define PIM_COND_LVLLO   3'h5
`define PIM_COND_LOW0    3'h6
`define PIM_COND_EVENT   3'h7
`define PIM_CFG_ENDPT    3

`endif

// >>> rtl/pim_chan.v
// one pin channel: synchroniser and edge detector
`timescale 1ns/1ps
module pim_chan (
   input  wire clock,
   input  wire arst_n,
   input  wire pinRaw,
   output wire level,
   output wire rise,
   output wire fall
);
   reg syncA;
   reg syncB;
   reg last;

   // two stages before anything looks at the pin
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         syncA <= 1'b0;
         syncB <= 1'b0;
         last  <= 1'b0;
      end else begin
         syncA <= pinRaw;
         syncB <= syncA;
         last  <= syncB;
      end
   end

   assign level = syncB;
   assign rise  = syncB & ~last;
   assign fall  = ~syncB & last;
endmodule

// >>> rtl/pim_top.v
// pin interrupt and pattern match block with apb registers
//
// Behaviour
// RL1: eight selectable pins, edge or level each
// RL2: one interrupt line per pin channel
// RL3: edge channels trigger rising, falling or both
// RL4: level channels assert while active level holds
// RL5: pin interrupts can raise the wake indication
// RL6: pattern engine evaluates levels/transitions over pins
// RL7: each product term has its own request
// RL8: any match can notify cpu, routable to pin
// RL9: pattern matches never wake the device
// RL10: any digital pin selectable, whatever its function
// RL11: registers answer every access in one cycle
// RL12: pin inputs synchronised before detection
`timescale 1ns/1ps
`include "pim_consts.vh"
module pim_top (
   input  wire        clock,
   input  wire        arst_n,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output reg         pslverr,
   input  wire [63:0] pins,
   output wire [7:0]  pinIrq,
   output wire [7:0]  termIrq,
   output wire        wakeReq,
   output reg         cpuEventNotify,
   output reg         eventPin,
   output wire        irq
);
   reg  [31:0] sel0;
   reg  [31:0] sel1;
   reg  [7:0]  modeLevel;
   reg  [7:0]  enRise;
   reg  [7:0]  enFall;
   reg  [7:0]  riseFlag;
   reg  [7:0]  fallFlag;
   reg  [7:0]  wakeEn;
   reg  [31:0] pmSrc;
   reg  [31:0] pmCfg;
   reg         evEnable;
   reg  [15:0] iStat;
   reg  [15:0] iMask;
   reg  [7:0]  pmRise;
   reg  [7:0]  pmFall;
   reg  [7:0]  termLast;
   reg  [7:0]  pinRaw;
   reg  [7:0]  sliceTrue;
   reg  [7:0]  termNow;
   reg         acc;
   reg  [31:0] next_prdata;
   reg         hit;
   wire [7:0]  lvl;
   wire [7:0]  rise;
   wire [7:0]  fall;
   wire [63:0] selAll;
   wire        wrStrobe;
   wire        setup;
   wire [7:0]  termRise;
   wire [7:0]  edgeIrq;
   wire [7:0]  levelIrq;
   integer     i;
   genvar      g;

   assign selAll   = {sel1, sel0};
   assign setup    = psel & ~penable;
   assign wrStrobe = psel & penable & pwrite;
   // no wait states: every access closes in its access cycle
   assign pready   = 1'b1; // see RL11

   // pin picked by index, independent of the pin's own function
   always @* begin
      for (i = 0; i < `PIM_CH_N; i = i + 1) begin
         pinRaw[i] = pins[selAll[i*8 +: `PIM_SEL_W]]; // see RL1 see RL10
      end
   end

   generate
      for (g = 0; g < `PIM_CH_N; g = g + 1) begin : chan
         pim_chan u_chan (
            .clock  (clock),
            .arst_n (arst_n),
            .pinRaw (pinRaw[g]),
            .level  (lvl[g]),
            .rise   (rise[g]),
            .fall   (fall[g])
         ); // see RL12
      end
   endgenerate

   // edge channels: sticky flags gated by their enables
   assign edgeIrq  = (riseFlag & enRise) | (fallFlag & enFall); // see RL3
   // level channels: enRise enables, enFall picks the active level (1 = high)
   assign levelIrq = enRise & ~(lvl ^ enFall); // see RL4
   assign pinIrq   = (modeLevel & levelIrq) | (~modeLevel & edgeIrq); // see RL2
   // only plain pin requests reach wake; pattern terms are kept out
   assign wakeReq  = |(pinIrq & wakeEn); // see RL5 see RL9

   // pattern slices: each slice tests one channel or is a constant (HIGH1, LOW0); endpoints close a term
   always @* begin
      sliceTrue = 8'h00;
      termNow   = 8'h00;
      acc       = 1'b1;
      for (i = 0; i < `PIM_CH_N; i = i + 1) begin
         case (pmCfg[i*4 +: 3])
            `PIM_COND_HIGH1:  sliceTrue[i] = 1'b1;
            `PIM_COND_RISE:   sliceTrue[i] = pmRise[i];
            `PIM_COND_FALL:   sliceTrue[i] = pmFall[i];
            `PIM_COND_EITHER: sliceTrue[i] = pmRise[i] | pmFall[i];
            `PIM_COND_LVLHI:  sliceTrue[i] = lvl[pmSrc[i*4 +: 3]];
            `PIM_COND_LVLLO:  sliceTrue[i] = ~lvl[pmSrc[i*4 +: 3]];
            `PIM_COND_LOW0:   sliceTrue[i] = 1'b0;
            `PIM_COND_EVENT:  sliceTrue[i] = rise[pmSrc[i*4 +: 3]] | fall[pmSrc[i*4 +: 3]];
            default:          sliceTrue[i] = 1'b0;
         endcase
         acc = acc & sliceTrue[i]; // see RL6
         if (pmCfg[i*4 + `PIM_CFG_ENDPT]) begin
            termNow[i] = acc;
            acc        = 1'b1;
         end
      end
   end

   assign termIrq  = termNow; // see RL7
   assign termRise = termNow & ~termLast;
   assign irq      = |(iStat & iMask);

   // apb register writes and hardware-set flags; set wins over write-one-to-clear
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sel0      <= `PIM_SEL_RST;
         sel1      <= `PIM_SEL1_RST;
         modeLevel <= 8'h00;
         enRise    <= 8'h00;
         enFall    <= 8'h00;
         riseFlag  <= 8'h00;
         fallFlag  <= 8'h00;
         wakeEn    <= 8'h00;
         pmSrc     <= `PIM_PMSRC_RST;
         pmCfg     <= `PIM_PMCFG_RST;
         evEnable  <= 1'b0;
         iStat     <= 16'h0000;
         iMask     <= 16'h0000;
         pmRise    <= 8'h00;
         pmFall    <= 8'h00;
         termLast  <= 8'h00;
      end else begin
         termLast <= termNow;
         if (wrStrobe) begin
            case (paddr)
               `PIM_OFF_SEL0:   sel0      <= pwdata;
               `PIM_OFF_SEL1:   sel1      <= pwdata;
               `PIM_OFF_MODE:   modeLevel <= pwdata[7:0];
               `PIM_OFF_ENRISE: enRise    <= pwdata[7:0];
               `PIM_OFF_ENFALL: enFall    <= pwdata[7:0];
               `PIM_OFF_WAKEEN: wakeEn    <= pwdata[7:0];
               `PIM_OFF_PMSRC:  pmSrc     <= pwdata;
               `PIM_OFF_PMCFG:  pmCfg     <= pwdata;
               `PIM_OFF_PMCTRL: evEnable  <= pwdata[`PIM_PMCTRL_EVEN];
               `PIM_OFF_IMASK:  iMask     <= pwdata[15:0];
               default: ;
            endcase
         end
         // changing the pattern restarts its sticky edge memory
         if (wrStrobe && (paddr == `PIM_OFF_PMSRC || paddr == `PIM_OFF_PMCFG)) begin
            pmRise <= 8'h00;
            pmFall <= 8'h00;
         end else begin
            for (i = 0; i < `PIM_CH_N; i = i + 1) begin
               if (rise[pmSrc[i*4 +: 3]])
                  pmRise[i] <= 1'b1;
               if (fall[pmSrc[i*4 +: 3]])
                  pmFall[i] <= 1'b1;
            end
         end
         // write-one-to-clear first, hardware set after so it wins
         if (wrStrobe && paddr == `PIM_OFF_EDGEFLAG) begin
            riseFlag <= (riseFlag & ~pwdata[7:0]) | rise; // see RL3
            fallFlag <= (fallFlag & ~pwdata[15:8]) | fall;
         end else begin
            riseFlag <= riseFlag | rise;
            fallFlag <= fallFlag | fall;
         end
         if (wrStrobe && paddr == `PIM_OFF_ISTAT)
            iStat <= (iStat & ~pwdata[15:0]) | {termRise, rise | fall};
         else
            iStat <= iStat | {termRise, rise | fall};
      end
   end

   // event notify is a pulse per new match; the pin copy is a level
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cpuEventNotify <= 1'b0;
         eventPin       <= 1'b0;
      end else begin
         cpuEventNotify <= evEnable & (|termRise); // see RL8
         eventPin       <= evEnable & (|termNow);
      end
   end

   // read data is latched in the setup cycle so it is stable in access
   always @* begin
      next_prdata = 32'h00000000;
      hit         = 1'b1;
      case (paddr)
         `PIM_OFF_SEL0:     next_prdata = sel0;
         `PIM_OFF_SEL1:     next_prdata = sel1;
         `PIM_OFF_MODE:     next_prdata = {24'h000000, modeLevel};
         `PIM_OFF_ENRISE:   next_prdata = {24'h000000, enRise};
         `PIM_OFF_ENFALL:   next_prdata = {24'h000000, enFall};
         `PIM_OFF_EDGEFLAG: next_prdata = {16'h0000, fallFlag, riseFlag};
         `PIM_OFF_PINSTATE: next_prdata = {16'h0000, pinIrq, lvl};
         `PIM_OFF_WAKEEN:   next_prdata = {24'h000000, wakeEn};
         `PIM_OFF_PMSRC:    next_prdata = pmSrc;
         `PIM_OFF_PMCFG:    next_prdata = pmCfg;
         `PIM_OFF_PMCTRL:   next_prdata = {termNow, 23'h000000, evEnable};
         `PIM_OFF_ISTAT:    next_prdata = {16'h0000, iStat};
         `PIM_OFF_IMASK:    next_prdata = {16'h0000, iMask};
         default:           hit = 1'b0;
      endcase
   end

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata  <= pwrite ? 32'h00000000 : next_prdata; // see RL11
         pslverr <= ~hit;
      end else if (!psel) begin
         pslverr <= 1'b0;
      end
   end
endmodule

// >>> dv/pim_top_chk.sv
// port assertions for the pin interrupt block
`timescale 1ns/1ps
`include "pim_consts.vh"
module pim_top_chk (
   input logic        clock,
   input logic        arst_n,
   input logic        psel,
   input logic        penable,
   input logic [7:0]  paddr,
   input logic [31:0] prdata,
   input logic        pready,
   input logic        pslverr,
   input logic [7:0]  pinIrq,
   input logic [7:0]  termIrq,
   input logic        wakeReq,
   input logic        cpuEventNotify,
   input logic        eventPin
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   // unaligned offsets left out: their decode is not fixed at the ports
   wire unm = paddr > `PIM_OFF_IMASK && paddr[1:0] == 2'h0;
   wire map = paddr <= `PIM_OFF_IMASK && paddr[1:0] == 2'h0;
   ready_hi_a: assert property (pready) else $error("wait state seen");
   rd_hold_a: assert property (psel && !penable |-> ##2 $stable(prdata))
      else $error("read data moved");
   err_unmap_a: assert property (psel && penable && unm |-> pslverr)
      else $error("no error on unmapped");
   err_map_a: assert property (psel && penable && map |-> !pslverr)
      else $error("error on mapped");
   wake_pin_a: assert property (wakeReq |-> pinIrq != 8'h00)
      else $error("wake without pin request");
   notify_new_a: assert property (
      cpuEventNotify |-> ($past(termIrq) & ~$past(termIrq, 2)) != 8'h00)
      else $error("notify without new match");
   notify_pin_a: assert property (cpuEventNotify |-> eventPin)
      else $error("notify without event level");
   evpin_term_a: assert property (eventPin |-> $past(termIrq) != 8'h00)
      else $error("event level without term");
endmodule

// >>> dv/pim_cpu_model.sv
// interrupt controller and event input model facing the block
`timescale 1ns/1ps
module pim_cpu_model (
   input  logic       clock,
   input  logic       arst_n,
   input  logic       cpuEventNotify,
   input  logic [7:0] pinIrq,
   output int         notifyCount,
   output logic [7:0] pending
);
   // each line latched apart, so one source never hides another
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         notifyCount <= 0;
         pending <= 8'h00;
      end else begin
         if (cpuEventNotify) begin
            notifyCount <= notifyCount + 1;
         end
         pending <= pending | pinIrq;
      end
   end
endmodule

// >>> dv/tb.sv
// self-checking bench for the pin interrupt block
`timescale 1ns/1ps
`include "pim_consts.vh"
module tb;
   logic        clock = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic [63:0] pins = 64'h0;
   logic        pready, pslverr, wakeReq, cpuEventNotify, eventPin, irq, e;
   logic [7:0]  pinIrq, termIrq, pending;
   int          failures = 0, check_count = 0, notifyCount;
   // {level mode, rise/enable, fall/active high, pin start, pin end, expected line}
   logic [5:0]  rows [9] = '{6'h13, 6'h14, 6'h0d, 6'h0a, 6'h1d, 6'h3b, 6'h3c, 6'h35, 6'h32};
   always #5 clock = ~clock;
   pim_top i_dut (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pins(pins), .pinIrq(pinIrq), .termIrq(termIrq), .wakeReq(wakeReq),
      .cpuEventNotify(cpuEventNotify), .eventPin(eventPin), .irq(irq));
   pim_cpu_model i_cpu (.clock(clock), .arst_n(arst_n), .cpuEventNotify(cpuEventNotify),
      .pinIrq(pinIrq), .notifyCount(notifyCount), .pending(pending));
   task conclude;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // request held from setup until pready is sampled high
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         failures++;
         conclude;
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   initial begin
      repeat (20) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      apb(1'b0, `PIM_OFF_SEL0, 32'h0);
      chk(q, `PIM_SEL_RST);
      apb(1'b0, `PIM_OFF_PMSRC, 32'h0);
      chk(q, `PIM_PMSRC_RST);
      apb(1'b0, 8'h40, 32'h0);
      chk(q, 32'h0);
      chk(e, 32'h1);
      foreach (rows[i]) begin
         pins[0] <= rows[i][2];
         repeat (4) @(posedge clock);
         wr(`PIM_OFF_MODE, {31'h0, rows[i][5]});
         wr(`PIM_OFF_ENRISE, {31'h0, rows[i][4]});
         wr(`PIM_OFF_ENFALL, {31'h0, rows[i][3]});
         wr(`PIM_OFF_EDGEFLAG, 32'hffff);
         pins[0] <= rows[i][1];
         repeat (4) @(posedge clock);
         chk(pinIrq, {7'h0, rows[i][0]});
         $display("row %0d done", i);
      end
      wr(`PIM_OFF_SEL1, 32'h3f060504);
      wr(`PIM_OFF_MODE, 32'h0);
      wr(`PIM_OFF_ENRISE, 32'h80);
      wr(`PIM_OFF_ENFALL, 32'h0);
      wr(`PIM_OFF_EDGEFLAG, 32'hffff);
      wr(`PIM_OFF_ISTAT, 32'hffffffff);
      wr(`PIM_OFF_IMASK, 32'h1);
      pins[63] <= 1'b1;
      repeat (4) @(posedge clock);
      chk(pinIrq, 8'h80);
      chk(irq, 1'b0);
      wr(`PIM_OFF_WAKEEN, 32'h80);
      chk(wakeReq, 1'b1);
      wr(`PIM_OFF_IMASK, 32'h80);
      chk(irq, 1'b1);
      wr(`PIM_OFF_ISTAT, 32'h80);
      chk(irq, 1'b0);
      wr(`PIM_OFF_EDGEFLAG, 32'h80);
      chk(pinIrq, 8'h00);
      chk(pending, 8'h81);
      $display("select test done");
      pins[0] <= 1'b0;
      repeat (4) @(posedge clock);
      wr(`PIM_OFF_PMCFG, 32'hc);
      wr(`PIM_OFF_PMCTRL, 32'h1);
      wr(`PIM_OFF_ISTAT, 32'hffffffff);
      wr(`PIM_OFF_IMASK, 32'h100);
      pins[0] <= 1'b1;
      // one edge more so the model's count, launched at the fourth edge, has settled
      repeat (5) @(posedge clock);
      chk(termIrq, 8'h01);
      chk(eventPin, 1'b1);
      chk(notifyCount, 32'h1);
      chk(wakeReq, 1'b0);
      chk(irq, 1'b1);
      $display("pattern test done");
      // slice0 sticky rise, slice1 channel 1 low closes term 1
      wr(`PIM_OFF_PMCFG, 32'hd1);
      chk(termIrq, 8'h00);
      pins[0] <= 1'b0;
      repeat (4) @(posedge clock);
      pins[0] <= 1'b1;
      repeat (5) @(posedge clock);
      chk(termIrq, 8'h02);
      pins[1] <= 1'b1;
      repeat (5) @(posedge clock);
      chk(termIrq, 8'h00);
      chk(notifyCount, 32'h2);
      $display("sticky term test done");
      arst_n <= 1'b0;
      repeat (2) @(posedge clock);
      chk({pinIrq, termIrq, eventPin, irq}, 32'h0);
      arst_n <= 1'b1;
      @(posedge clock);
      $display("reset test done");
      conclude;
   end
endmodule
bind pim_top pim_top_chk i_chk (.clock(clock), .arst_n(arst_n), .psel(psel),
   .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pinIrq(pinIrq), .termIrq(termIrq), .wakeReq(wakeReq),
   .cpuEventNotify(cpuEventNotify), .eventPin(eventPin));
